// ==== hw/eco_consts.svh ====
`ifndef ECO_CONSTS_SVH
`define ECO_CONSTS_SVH

// =====================================================
// Control word and descriptor bit positions
`define ECO_CR_RX_EN_BIT      0
`define ECO_CR_RX_MODE_BIT    1
`define ECO_CR_TX_EN_BIT      16
`define ECO_D1_SUM_REQ_BIT    27
`define ECO_D1_FIRST_SEG_BIT  29

// =====================================================
// Transmit preamble fields
`define ECO_PRE_START_MSB     11
`define ECO_PRE_START_LSB     0
`define ECO_PRE_LOC_MSB       27
`define ECO_PRE_LOC_LSB       16
`define ECO_PRE_BYTES         2'd3

// =====================================================
// Frame layout and reset values
`define ECO_HDR_BYTES         12'd14
`define ECO_VLAN_SKIP         12'd4
`define ECO_SNAP_SKIP         12'd8
`define ECO_MAX_VLAN          2'd2
`define ECO_LEN_TYPE_MIN      16'h0600
`define ECO_VLAN_TAG_RST      16'h8100
`define ECO_SUM_BYTES         16'd2
`define ECO_FIFO_DEPTH        16

`endif

// ==== hw/eco_device.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eco_consts.svh"
module eco_device #(
   parameter int FIFO_DEPTH = `ECO_FIFO_DEPTH,
   parameter int TX_BYTES   = 4096
) (
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   eco_link_if.dev   link_io
);
   import eco_pkg::*;

   // Ones-complement add with end-around carry; cannot carry twice
   function automatic logic [15:0] eco_add(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'd0, s[16]};
   endfunction

   // =====================================================
   // Receive engine
   eco_rx_state_t    rx_state_q;
   logic [11:0]      rx_cnt_q;
   logic [11:0]      start_q;
   logic [1:0]       tags_q;
   logic             snap_q;
   logic             parse_q;
   logic [7:0]       prev_q;
   logic [15:0]      acc_q;
   logic [7:0]       lo_q;
   logic             odd_q;
   logic [15:0]      sum_q;
   logic [15:0]      len_q;
   logic [3:0][7:0]  dl_byte_q;
   logic [3:0]       dl_sum_q;
   logic [3:0]       dl_vld_q;
   logic             f_in_valid;
   logic [8:0]       f_in_data;
   logic             f_in_ready;
   logic [8:0]       f_out_data;

   wire        rx_en    = link_io.ctrl[`ECO_CR_RX_EN_BIT];
   wire        rx_mode  = link_io.ctrl[`ECO_CR_RX_MODE_BIT];
   wire        rx_rdy   = (rx_state_q == RX_DATA) && f_in_ready;
   wire        rx_take  = link_io.rxi_valid && rx_rdy;
   wire        rx_end   = rx_take && link_io.rxi_last;
   wire [15:0] rx_type  = {prev_q, link_io.rxi_data};
   wire        type_at  = rx_take && rx_en && rx_mode && parse_q
                          && (rx_cnt_q == start_q - 12'd1);
   wire        in_sum   = rx_en && (rx_cnt_q >= start_q);
   // Oldest delay byte leaves; the last four never leave, so FCS is excluded
   wire        dl_out   = rx_take && dl_vld_q[3] && dl_sum_q[3];
   wire [15:0] rx_fin   = odd_q ? eco_add(acc_q, {8'h00, lo_q}) : acc_q;

   assign link_io.rxi_ready = rx_rdy;
   assign link_io.rxo_len   = len_q;

   // Stream mux into FIFO: data, then two sum bytes when enabled
   always_comb begin
      f_in_valid = 1'b0;
      f_in_data  = {link_io.rxi_last && !rx_en, link_io.rxi_data};
      case (rx_state_q)
         RX_DATA: f_in_valid = link_io.rxi_valid;
         RX_SUM_LO: begin
            f_in_valid = 1'b1;
            f_in_data  = {1'b0, rx_fin[7:0]};
         end
         RX_SUM_HI: begin
            f_in_valid = 1'b1;
            f_in_data  = {1'b1, sum_q[15:8]};
         end
         default: f_in_valid = 1'b0;
      endcase
   end

   // Sequencing of receive frame and sum bytes
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         rx_state_q <= RX_DATA;
         sum_q      <= 16'h0000;
         len_q      <= 16'h0000;
      end else begin
         case (rx_state_q)
            RX_DATA: begin
               if (rx_end) begin
                  rx_state_q <= rx_en ? RX_SUM_LO : RX_DATA;
                  len_q      <= {4'h0, rx_cnt_q} + 16'd1 + (rx_en ? `ECO_SUM_BYTES : 16'd0);
               end
            end
            RX_SUM_LO: begin
               if (f_in_ready) begin
                  sum_q      <= rx_fin;
                  rx_state_q <= RX_SUM_HI;
               end
            end
            RX_SUM_HI: if (f_in_ready) rx_state_q <= RX_DATA;
            default: rx_state_q <= RX_DATA;
         endcase
      end
   end

   // Header walk: VLAN tags, then an optional SNAP header
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         rx_cnt_q <= 12'd0;
         start_q  <= `ECO_HDR_BYTES;
         tags_q   <= 2'd0;
         snap_q   <= 1'b0;
         parse_q  <= 1'b1;
         prev_q   <= 8'h00;
      end else if (rx_end) begin
         rx_cnt_q <= 12'd0;
         start_q  <= `ECO_HDR_BYTES;
         tags_q   <= 2'd0;
         snap_q   <= 1'b0;
         parse_q  <= 1'b1;
      end else if (rx_take) begin
         rx_cnt_q <= rx_cnt_q + 12'd1;
         prev_q   <= link_io.rxi_data;
         if (type_at) begin
            if (rx_type == link_io.vlan_tag && tags_q != `ECO_MAX_VLAN) begin
               start_q <= start_q + `ECO_VLAN_SKIP;
               tags_q  <= tags_q + 2'd1;
            end else if (rx_type < `ECO_LEN_TYPE_MIN && !snap_q) begin
               start_q <= start_q + `ECO_SNAP_SKIP;
               snap_q  <= 1'b1;
            end else begin
               parse_q <= 1'b0;
            end
         end
      end
   end

   // Four-byte delay keeps the FCS out of the sum
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         dl_byte_q <= '0;
         dl_sum_q  <= 4'h0;
         dl_vld_q  <= 4'h0;
      end else if (rx_end) begin
         dl_vld_q  <= 4'h0;
      end else if (rx_take) begin
         dl_byte_q <= {dl_byte_q[2:0], link_io.rxi_data};
         dl_sum_q  <= {dl_sum_q[2:0], in_sum};
         dl_vld_q  <= {dl_vld_q[2:0], 1'b1};
      end
   end

   // Word accumulation: earlier byte low, later byte high
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         acc_q <= 16'h0000;
         lo_q  <= 8'h00;
         odd_q <= 1'b0;
      end else if (rx_state_q == RX_SUM_HI && f_in_ready) begin
         acc_q <= 16'h0000;
         odd_q <= 1'b0;
      end else if (dl_out) begin
         if (!odd_q) begin
            lo_q  <= dl_byte_q[3];
            odd_q <= 1'b1;
         end else begin
            acc_q <= eco_add(acc_q, {dl_byte_q[3], lo_q});
            odd_q <= 1'b0;
         end
      end
   end

   // Output buffer toward the DMA; its ready stalls the engine
   eco_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk_in        (clk_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (f_in_valid),
      .in_data_in    (f_in_data),
      .in_ready_out  (f_in_ready),
      .out_valid_out (link_io.rxo_valid),
      .out_data_out  (f_out_data),
      .out_ready_in  (link_io.rxo_ready)
   );
   assign link_io.rxo_data = f_out_data[7:0];
   assign link_io.rxo_last = f_out_data[8];
   assign link_io.rx_idle  = (rx_state_q == RX_DATA) && (rx_cnt_q == 12'd0)
                             && !link_io.rxo_valid;

   // =====================================================
   // Transmit engine: store, sum, then send with insertion
   eco_tx_state_t tx_state_q;
   logic [7:0]    tx_mem_q [TX_BYTES];
   logic [11:0]   wr_q;
   logic [11:0]   rd_q;
   logic [31:0]   pre_q;
   logic [1:0]    pre_cnt_q;
   logic [15:0]   tacc_q;
   logic [7:0]    tlo_q;
   logic          todd_q;
   logic [7:0]    txo_data;
   logic          txo_valid;
   logic          txo_last;
   logic          txi_rdy;

   wire        tx_go    = link_io.txi_desc1[`ECO_D1_SUM_REQ_BIT]
                          && link_io.txi_desc1[`ECO_D1_FIRST_SEG_BIT]
                          && link_io.ctrl[`ECO_CR_TX_EN_BIT];
   wire [11:0] t_start  = pre_q[`ECO_PRE_START_MSB:`ECO_PRE_START_LSB];
   wire [11:0] t_loc    = pre_q[`ECO_PRE_LOC_MSB:`ECO_PRE_LOC_LSB];
   wire        tx_take  = link_io.txi_valid && txi_rdy;
   wire        tx_out   = txo_valid && link_io.txo_ready;
   wire [15:0] t_fin    = todd_q ? eco_add(tacc_q, {8'h00, tlo_q}) : tacc_q;
   wire [15:0] t_ins    = ~t_fin;

   // Outgoing byte; sum overwrites two bytes in flight
   always_comb begin
      txi_rdy   = 1'b0;
      txo_valid = 1'b0;
      txo_data  = link_io.txi_data;
      txo_last  = link_io.txi_last;
      case (tx_state_q)
         TX_PRE, TX_LOAD: txi_rdy = 1'b1;
         TX_PASS: begin
            txi_rdy   = link_io.txo_ready;
            txo_valid = link_io.txi_valid;
         end
         TX_SEND: begin
            txo_valid = 1'b1;
            txo_last  = (rd_q == wr_q - 12'd1);
            if (rd_q == t_loc) txo_data = t_ins[7:0];
            else if (rd_q == t_loc + 12'd1) txo_data = t_ins[15:8];
            else txo_data = tx_mem_q[rd_q];
         end
         default: txi_rdy = 1'b0;
      endcase
   end
   assign link_io.txi_ready = txi_rdy;
   assign link_io.txo_data  = txo_data;
   assign link_io.txo_valid = txo_valid;
   assign link_io.txo_last  = txo_last;
   assign link_io.tx_idle   = (tx_state_q == TX_IDLE);

   // Packet sequencing and transmit sum
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         tx_state_q <= TX_IDLE;
         wr_q       <= 12'd0;
         rd_q       <= 12'd0;
         pre_q      <= 32'h0000_0000;
         pre_cnt_q  <= 2'd0;
         tacc_q     <= 16'h0000;
         tlo_q      <= 8'h00;
         todd_q     <= 1'b0;
      end else begin
         case (tx_state_q)
            TX_IDLE: begin
               wr_q      <= 12'd0;
               rd_q      <= 12'd0;
               pre_cnt_q <= 2'd0;
               tacc_q    <= 16'h0000;
               todd_q    <= 1'b0;
               if (link_io.txi_valid) tx_state_q <= tx_go ? TX_PRE : TX_PASS;
            end
            TX_PRE: if (tx_take) begin
               pre_q     <= {link_io.txi_data, pre_q[31:8]};
               pre_cnt_q <= pre_cnt_q + 2'd1;
               if (pre_cnt_q == `ECO_PRE_BYTES) tx_state_q <= TX_LOAD;
            end
            TX_LOAD: if (tx_take) begin
               wr_q <= wr_q + 12'd1;
               if (wr_q >= t_start) begin
                  if (!todd_q) begin
                     tlo_q  <= link_io.txi_data;
                     todd_q <= 1'b1;
                  end else begin
                     tacc_q <= eco_add(tacc_q, {link_io.txi_data, tlo_q});
                     todd_q <= 1'b0;
                  end
               end
               if (link_io.txi_last) tx_state_q <= TX_SEND;
            end
            TX_SEND: if (tx_out) begin
               rd_q <= rd_q + 12'd1;
               if (txo_last) tx_state_q <= TX_IDLE;
            end
            TX_PASS: if (tx_take && link_io.txi_last) tx_state_q <= TX_IDLE;
            default: tx_state_q <= TX_IDLE;
         endcase
      end
   end

   // Packet store
   always_ff @(posedge clk_in) begin
      if (tx_state_q == TX_LOAD && tx_take) tx_mem_q[wr_q] <= link_io.txi_data;
   end
endmodule
`default_nettype wire

// ==== hw/eco_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module eco_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic      [WIDTH-1:0] out_data_out,
   input  wire logic             out_ready_in
);
   import eco_pkg::*;
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   wire              full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire              empty = (wr_q == rd_q);
   wire              push  = in_valid_in && !full;
   wire              pop   = out_ready_in && !empty;

   // Handshake straight from pointer state
   assign in_ready_out  = !full;
   assign out_valid_out = !empty;
   assign out_data_out  = mem_q[rd_q[AW-1:0]];

   // =====================================================
   // Pointers; extra bit tells full from empty
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop)  rd_q <= rd_q + 1'b1;
      end
   end

   // Storage needs no reset
   always_ff @(posedge clk_in) begin
      if (push) mem_q[wr_q[AW-1:0]] <= in_data_in;
   end
endmodule
`default_nettype wire

// ==== hw/eco_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eco_consts.svh"
module eco_host (
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   eco_link_if.host         link_io,
   input  wire logic [31:0] control_word_in,
   input  wire logic [15:0] vlan_tag_in,
   input  wire logic        pad_strip_enable_in,
   output logic             pad_strip_enable_out,
   input  wire logic [7:0]  mac_rx_data_in,
   input  wire logic        mac_rx_valid_in,
   input  wire logic        mac_rx_last_in,
   output logic             mac_rx_ready_out,
   output logic [7:0]       dma_rx_data_out,
   output logic             dma_rx_valid_out,
   output logic             dma_rx_last_out,
   output logic [15:0]      dma_rx_len_out,
   input  wire logic        dma_rx_ready_in,
   input  wire logic [7:0]  dma_tx_data_in,
   input  wire logic        dma_tx_valid_in,
   input  wire logic        dma_tx_last_in,
   input  wire logic [31:0] dma_tx_desc1_in,
   output logic             dma_tx_ready_out,
   output logic [7:0]       mac_tx_data_out,
   output logic             mac_tx_valid_out,
   output logic             mac_tx_last_out,
   input  wire logic        mac_tx_ready_in
);
   import eco_pkg::*;

   logic [31:0] ctrl_q;
   logic [15:0] vlan_q;
   logic        rx_mid_q;
   logic        tx_mid_q;
   logic        pad_q;

   // Pending setting changes hold new frames off until the path drains
   wire rx_pend = (control_word_in[`ECO_CR_RX_MODE_BIT:`ECO_CR_RX_EN_BIT]
                   != ctrl_q[`ECO_CR_RX_MODE_BIT:`ECO_CR_RX_EN_BIT])
                  || (vlan_tag_in != vlan_q);
   wire tx_pend = control_word_in[`ECO_CR_TX_EN_BIT] != ctrl_q[`ECO_CR_TX_EN_BIT];
   wire rx_gate = rx_pend && !rx_mid_q;
   wire tx_gate = tx_pend && !tx_mid_q;

   // =====================================================
   // Stream joins; gating only between frames
   assign link_io.ctrl      = ctrl_q;
   assign link_io.vlan_tag  = vlan_q;
   assign link_io.rxi_data  = mac_rx_data_in;
   assign link_io.rxi_valid = mac_rx_valid_in && !rx_gate;
   assign link_io.rxi_last  = mac_rx_last_in;
   assign mac_rx_ready_out  = link_io.rxi_ready && !rx_gate;
   assign dma_rx_data_out   = link_io.rxo_data;
   assign dma_rx_valid_out  = link_io.rxo_valid;
   assign dma_rx_last_out   = link_io.rxo_last;
   assign dma_rx_len_out    = link_io.rxo_len;
   assign link_io.rxo_ready = dma_rx_ready_in;
   assign link_io.txi_data  = dma_tx_data_in;
   assign link_io.txi_valid = dma_tx_valid_in && !tx_gate;
   assign link_io.txi_last  = dma_tx_last_in;
   assign link_io.txi_desc1 = dma_tx_desc1_in;
   assign dma_tx_ready_out  = link_io.txi_ready && !tx_gate;
   assign mac_tx_data_out   = link_io.txo_data;
   assign mac_tx_valid_out  = link_io.txo_valid;
   assign mac_tx_last_out   = link_io.txo_last;
   assign link_io.txo_ready = mac_tx_ready_in;
   assign pad_strip_enable_out = pad_q;

   wire rx_take = link_io.rxi_valid && link_io.rxi_ready;
   wire tx_take = link_io.txi_valid && link_io.txi_ready;

   // Settings applied only while idle; pad strip forced off with sum on
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         ctrl_q   <= 32'h0000_0000;
         vlan_q   <= `ECO_VLAN_TAG_RST;
         rx_mid_q <= 1'b0;
         tx_mid_q <= 1'b0;
         pad_q    <= 1'b0;
      end else begin
         if (rx_take) rx_mid_q <= !link_io.rxi_last;
         if (tx_take) tx_mid_q <= !link_io.txi_last;
         if (rx_gate && link_io.rx_idle) begin
            ctrl_q[`ECO_CR_RX_MODE_BIT:`ECO_CR_RX_EN_BIT] <=
               control_word_in[`ECO_CR_RX_MODE_BIT:`ECO_CR_RX_EN_BIT];
            vlan_q <= vlan_tag_in;
         end
         if (tx_gate && link_io.tx_idle) begin
            ctrl_q[`ECO_CR_TX_EN_BIT] <= control_word_in[`ECO_CR_TX_EN_BIT];
         end
         pad_q <= pad_strip_enable_in && !ctrl_q[`ECO_CR_RX_EN_BIT]
                  && !control_word_in[`ECO_CR_RX_EN_BIT];
      end
   end
endmodule
`default_nettype wire

// ==== hw/eco_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface eco_link_if;
   logic [31:0] ctrl;
   logic [15:0] vlan_tag;
   logic [7:0]  rxi_data;
   logic        rxi_valid;
   logic        rxi_last;
   logic        rxi_ready;
   logic [7:0]  rxo_data;
   logic        rxo_valid;
   logic        rxo_last;
   logic        rxo_ready;
   logic [15:0] rxo_len;
   logic [7:0]  txi_data;
   logic        txi_valid;
   logic        txi_last;
   logic [31:0] txi_desc1;
   logic        txi_ready;
   logic [7:0]  txo_data;
   logic        txo_valid;
   logic        txo_last;
   logic        txo_ready;
   logic        rx_idle;
   logic        tx_idle;

   modport dev (
      input  ctrl, vlan_tag, rxi_data, rxi_valid, rxi_last, rxo_ready,
             txi_data, txi_valid, txi_last, txi_desc1, txo_ready,
      output rxi_ready, rxo_data, rxo_valid, rxo_last, rxo_len,
             txi_ready, txo_data, txo_valid, txo_last, rx_idle, tx_idle
   );
   modport host (
      output ctrl, vlan_tag, rxi_data, rxi_valid, rxi_last, rxo_ready,
             txi_data, txi_valid, txi_last, txi_desc1, txo_ready,
      input  rxi_ready, rxo_data, rxo_valid, rxo_last, rxo_len,
             txi_ready, txo_data, txo_valid, txo_last, rx_idle, tx_idle
   );
endinterface
`default_nettype wire

// ==== hw/eco_pkg.sv ====
package eco_pkg;
   typedef enum logic [1:0] {RX_DATA, RX_SUM_LO, RX_SUM_HI} eco_rx_state_t;
   typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_LOAD, TX_SEND, TX_PASS} eco_tx_state_t;
endpackage

// ==== test/eco_link_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module eco_link_props (
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic [31:0] ctrl,
   input wire logic        rxi_valid,
   input wire logic        rxi_ready,
   input wire logic        rxi_last,
   input wire logic        rxo_valid,
   input wire logic        rxo_ready,
   input wire logic [7:0]  rxo_data,
   input wire logic        rxo_last,
   input wire logic [15:0] rxo_len,
   input wire logic        txi_valid,
   input wire logic        txi_ready,
   input wire logic [7:0]  txi_data,
   input wire logic [31:0] txi_desc1,
   input wire logic        txo_valid,
   input wire logic        txo_ready,
   input wire logic [7:0]  txo_data,
   input wire logic        tx_idle
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic        rx_take;
   logic        tx_go;
   // ======================================
   // Helpers: byte count of the frame in flight
   assign rx_take = rxi_valid && rxi_ready;
   assign tx_go   = txi_desc1[27] && txi_desc1[29] && ctrl[16];
   assign cnt_d   = (rx_take && rxi_last) ? 16'h0000 : cnt_q + {15'h0000, rx_take};
   // Count restarts on reset, so a cut frame never skews the next length
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   // ======================================
   // Properties
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   property p_len;
      rx_take && rxi_last |=> rxo_len == $past(cnt_q) + 16'h0001 + (ctrl[0] ? 16'h0002 : 16'h0000);
   endproperty
   a_len: assert property (p_len) else $error("frame length off");
   property p_gap;
      ctrl[0] && rx_take && rxi_last |=> !rxi_ready [*2];
   endproperty
   a_gap: assert property (p_gap) else $error("input not held for sum bytes");
   property p_fill;
      rx_take && !rxo_valid |=> rxo_valid;
   endproperty
   a_fill: assert property (p_fill) else $error("byte not forwarded");
   property p_rx_hold;
      rxo_valid && !rxo_ready |=> rxo_valid && $stable(rxo_data) && $stable(rxo_last);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("receive output moved");
   property p_tx_hold;
      txo_valid && !txo_ready |=> txo_valid && $stable(txo_data);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("transmit output moved");
   property p_idle_ref;
      tx_idle && txi_valid |-> !txi_ready;
   endproperty
   a_idle_ref: assert property (p_idle_ref) else $error("byte taken before decision");
   property p_pass;
      tx_idle && txi_valid && !tx_go |=> txo_valid == txi_valid && txo_data == txi_data;
   endproperty
   a_pass: assert property (p_pass) else $error("pass path not mirrored");
   property p_pre;
      tx_idle && txi_valid && tx_go |=> !txo_valid [*5];
   endproperty
   a_pre: assert property (p_pre) else $error("preamble leaked out");
endmodule
`default_nettype wire

// ==== test/ethernet_checksum_offload_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ethernet_checksum_offload_tb_top;
   logic        clk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic [31:0] cw = 32'h0000_0000;
   logic [31:0] desc = 32'h0000_0000;
   logic [15:0] vt = 16'h8100;
   logic [15:0] dlen;
   logic [7:0]  rd = 8'h00;
   logic [7:0]  td = 8'h00;
   logic [7:0]  drd;
   logic [7:0]  mtd;
   logic        rv = 1'b0, rl = 1'b0, tv = 1'b0, tl = 1'b0, pad_in = 1'b0, dr_rdy = 1'b1;
   logic        rr, tr, drv, mtv, pad_out, saw_full, drl, mtl, mt_rdy = 1'b1;
   logic [8:0]  rxq[$], txq[$];
   byte unsigned f[$], e[$];
   int          err_total = 0;
   int          compares = 0;
   eco_link_if link_if ();
   eco_device i_eco_device (.clk_in(clk_in), .rst_b_in(rst_b_in), .link_io(link_if.dev));
   eco_host i_eco_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .link_io(link_if.host),
      .control_word_in(cw), .vlan_tag_in(vt), .pad_strip_enable_in(pad_in),
      .pad_strip_enable_out(pad_out), .mac_rx_data_in(rd), .mac_rx_valid_in(rv),
      .mac_rx_last_in(rl), .mac_rx_ready_out(rr), .dma_rx_data_out(drd),
      .dma_rx_valid_out(drv), .dma_rx_last_out(drl), .dma_rx_len_out(dlen),
      .dma_rx_ready_in(dr_rdy), .dma_tx_data_in(td), .dma_tx_valid_in(tv),
      .dma_tx_last_in(tl), .dma_tx_desc1_in(desc), .dma_tx_ready_out(tr),
      .mac_tx_data_out(mtd), .mac_tx_valid_out(mtv), .mac_tx_last_out(mtl),
      .mac_tx_ready_in(mt_rdy));
   eco_link_props i_eco_link_props (.clk_in(clk_in), .rst_b_in(rst_b_in), .ctrl(link_if.ctrl),
      .rxi_valid(link_if.rxi_valid), .rxi_ready(link_if.rxi_ready), .rxi_last(link_if.rxi_last),
      .rxo_valid(link_if.rxo_valid), .rxo_ready(link_if.rxo_ready), .rxo_data(link_if.rxo_data),
      .rxo_last(link_if.rxo_last), .rxo_len(link_if.rxo_len), .txi_valid(link_if.txi_valid),
      .txi_ready(link_if.txi_ready), .txi_data(link_if.txi_data), .txi_desc1(link_if.txi_desc1),
      .txo_valid(link_if.txo_valid), .txo_ready(link_if.txo_ready), .txo_data(link_if.txo_data),
      .tx_idle(link_if.tx_idle));
   // ======================================
   // Clock and output capture
   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      if (drv && dr_rdy) rxq.push_back({drl, drd});
      if (mtv && mt_rdy) txq.push_back({mtl, mtd});
   end
   // Mac stalls every other cycle
   always @(negedge clk_in) mt_rdy = !mt_rdy;
   // ======================================
   // Checking and closing
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      if (err_total == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic expired;
      err_total++;
      $display("mismatch at %0t: wait expired %h %h", $time, rxq.size(), txq.size());
      conclude();
   endtask
   // Ones-complement sum, later byte high; odd tail gets a zero high byte
   function automatic logic [15:0] osum(input byte unsigned q[$], input int a, input int b);
      logic [16:0] s = 17'h0_0000;
      for (int i = a; i < b; i += 2) s = s[15:0] + s[16] + {(i + 1 < b) ? q[i+1] : 8'h00, q[i]};
      s = s[15:0] + s[16];
      return s[15:0] + s[16];
   endfunction
   // Layer 3 start: two tags at most, one length field means SNAP follows
   function automatic int l3start(input byte unsigned q[$], input logic [15:0] tag);
      int p = 12;
      for (int n = 0; n < 2 && {q[p], q[p+1]} == tag; n++) p += 4;
      if ({q[p], q[p+1]} < 16'h0600) p += 8;
      return p + 2;
   endfunction
   // ======================================
   // Stimulus, always entered at a falling edge
   task automatic set_cw(input logic [31:0] c);
      cw = c;
      repeat (4) @(negedge clk_in);
   endtask
   task automatic push(input bit tx, input byte unsigned q[$]);
      int w;
      foreach (q[i]) begin
         if (tx) {td, tv, tl} = {q[i], 1'b1, i == q.size() - 1};
         else {rd, rv, rl} = {q[i], 1'b1, i == q.size() - 1};
         #1;
         for (w = 0; !(tx ? tr : rr); w++) begin
            if (!tx && !dr_rdy) saw_full = 1'b1;
            if (w == 500) expired();
            @(negedge clk_in);
            #1;
         end
         @(negedge clk_in);
      end
      {tv, tl, rv, rl} = 4'h0;
   endtask
   task automatic expect_q(input bit tx, input byte unsigned x[$]);
      for (int w = 0; (tx ? txq.size() : rxq.size()) < x.size(); w++) begin
         if (w == 500) expired();
         @(negedge clk_in);
      end
      foreach (x[i]) chk(tx ? txq[i] : rxq[i], {7'h00, i == x.size() - 1, x[i]});
      if (tx) txq = {};
      else rxq = {};
   endtask
   task automatic mk(input byte unsigned mid[$], input int n);
      f = {};
      for (int i = 0; i < 12; i++) f.push_back(8'(i * 17 + 3));
      f = {f, mid};
      for (int i = 0; i < n + 4; i++) f.push_back(8'(i * 7 + 1));
   endtask
   task automatic rx_case(input logic [31:0] c, input byte unsigned mid[$], input int n, input bit st);
      logic [15:0] s;
      if (cw !== c) set_cw(c);
      mk(mid, n);
      e = f;
      s = osum(f, c[1] ? l3start(f, vt) : 14, f.size() - 4);
      if (c[0]) e = {e, s[7:0], s[15:8]};
      saw_full = 1'b0;
      dr_rdy = !st;
      fork
         push(1'b0, f);
         begin
            repeat (60) @(negedge clk_in);
            dr_rdy = 1'b1;
         end
      join
      if (st) chk({15'h0000, saw_full}, 16'h0001);
      expect_q(1'b0, e);
      chk(dlen, 16'(e.size()));
   endtask
   task automatic tx_case(input logic [31:0] d, input int st, input int lc, input int n, input bit z);
      logic [15:0] s;
      logic [31:0] pre;
      f = {};
      for (int i = 0; i < n; i++) f.push_back(z ? 8'h00 : 8'(i * 13 + 5));
      if (z) {f[lc], f[lc+1], f[lc+2], f[lc+3]} = 32'h1234_EDCB;
      e = f;
      desc = d;
      if (d[27] && d[29] && cw[16]) begin
         s = ~osum(f, st, n);
         {e[lc], e[lc+1]} = {s[7:0], s[15:8]};
         pre = {4'h0, 12'(lc), 4'h0, 12'(st)};
         f = {pre[7:0], pre[15:8], pre[23:16], pre[31:24], f};
      end
      push(1'b1, f);
      expect_q(1'b1, e);
   endtask
   // ======================================
   // Main sequence
   initial begin
      repeat (16) @(negedge clk_in);
      rst_b_in = 1'b1;
      @(negedge clk_in);
      rx_case(32'h0, '{8'h08, 8'h00}, 21, 1'b0);
      rx_case(32'h1, '{8'h08, 8'h00}, 21, 1'b0);
      rx_case(32'h1, '{8'h08, 8'h00}, 40, 1'b1);
      pad_in = 1'b1;
      @(negedge clk_in);
      chk({15'h0000, pad_out}, 16'h0000);
      rx_case(32'h3, '{8'h08, 8'h00}, 15, 1'b0);
      rx_case(32'h3, '{8'h81, 8'h00, 8'h00, 8'h05, 8'h81, 8'h00, 8'h00, 8'h06, 8'h00, 8'h2E,
         8'hAA, 8'hAA, 8'h03, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00}, 20, 1'b0);
      rx_case(32'h3, '{8'h81, 8'h00, 8'h00, 8'h01, 8'h81, 8'h00, 8'h00, 8'h02,
         8'h81, 8'h00, 8'h00, 8'h03}, 20, 1'b0);
      vt = 16'h88A8;
      set_cw(32'h3);
      rx_case(32'h3, '{8'h88, 8'hA8, 8'h00, 8'h07, 8'h08, 8'h00}, 19, 1'b0);
      set_cw(32'h0001_0000);
      tx_case(32'h2800_0000, 15, 30, 61, 1'b0);
      tx_case(32'h2800_0000, 14, 20, 40, 1'b1);
      tx_case(32'h0800_0000, 14, 20, 40, 1'b0);
      set_cw(32'h0000_0000);
      tx_case(32'h2800_0000, 14, 20, 40, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
